// [pkg/rsw_pkg.sv]
// constants for the reset, sleep and wake status block
package rsw_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_PCL    = 8'h02; // program counter low byte
  localparam logic [7:0] OFS_STATUS = 8'h03; // status flags
  localparam logic [7:0] OFS_PORT   = 8'h06; // port pins, access latches
  localparam logic [7:0] OFS_CONFIG = 8'h07; // wake and protect options

  // ****************************************
  // status field positions and reset values
  // ****************************************
  localparam int          ST_WAKE   = 7; // pin wake flag
  localparam int          ST_TO     = 4; // timeout flag, active low
  localparam int          ST_PD     = 3; // powerdown flag, active low
  localparam logic [7:0]  ST_POR    = 8'h18; // power-up value
  localparam logic [7:0]  ST_WR_MSK = 8'h67; // software writable bits
  localparam logic [7:0]  PCL_RST   = 8'hff; // low byte after any reset
  localparam logic [2:0]  UP_MASTER_CLEAR_N_S = 3'b000; // bits 7:5 on clear running
  localparam logic [4:0]  UP_WDT_S  = 5'b0_0000;
  localparam logic [4:0]  UP_MASTER_CLEAR_N_Z = 5'b0_0010;
  localparam logic [4:0]  UP_PIN_W  = 5'b1_0010;

  // ****************************************
  // configuration bits
  // ****************************************
  localparam int          CF_WDT    = 0; // watchdog enable
  localparam int          CF_WAKE   = 1; // wake on pin change enable
  localparam int          CF_MASTER_CLEAR_N   = 2; // pin 3 acts as master clear
  localparam int          CF_CP     = 3; // code protection enabled
  localparam int          CF_LATE   = 4; // last word always readable
  localparam logic [7:0]  CFG_RST   = 8'h05;
  localparam logic [5:0]  WAKE_MSK  = 6'b00_1011; // pins 0, 1 and 3

  // ****************************************
  // program and verify map
  // ****************************************
  localparam int          OPEN_WORDS = 64; // readable whatever protection
  localparam int          ID_WORDS   = 4;
  localparam logic [5:0]  OE_N_RST   = 6'b11_1111; // all pins floating

  // ****************************************
  // sleep state machine
  // ****************************************
  typedef enum logic [1:0] {
    RSW_RUN   = 2'b01,
    RSW_SLEEP = 2'b10
  } rsw_state_e;

endpackage

// [verilog/rsw_core.sv]
// reset cause flags, sleep and wake control, protected readout
// ****************************************
// Operation
// - every reset source loads the program counter low byte with ones
// - master clear while running clears bits 7:5, keeps the rest
// - master clear while sleeping gives upper status bits 00010
// - watchdog timeout while sleeping gives upper status bits 00000
// - watchdog timeout while running clears bits 7:4, keeps the rest
// - pin change wake gives upper status bits 10010
// - powerdown flag set at power-up, cleared by sleep
// - sleep clears watchdog, sets timeout, clears powerdown, stops osc
// - pins keep their drive state while sleeping
// - watchdog reset never drives the master clear pin
// - sleep ends on clear, watchdog timeout or enabled pin change
// - watchdog timeout clears the timeout flag, also from sleep
// - asleep, pins 0, 1, 3 unlike the latched values wake the device
// - unread pins after a wake make the next sleep end at once
// - watchdog cleared on every wake from sleep
// - flags hold until the next reset event or sleep entry
// - unprotected device reads out all program memory
// - first 64 words are always readable
// - last word blocked when protected, unless the late variant option
// - four id words reachable only in program and verify mode
// - status bit 7 is one only after a pin change wake
// ****************************************
module rsw_core
  import rsw_pkg::*;
#(
  parameter int WDT_LIMIT = 1000,
  parameter int MEM_WORDS = 512,
  parameter int WORD_W    = 12,
  parameter int PV_AW     = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              sleep_cmd,
  input  wire logic              master_clear_n,
  input  wire logic [5:0]        port_pins,
  input  wire logic [5:0]        io_drive,
  input  wire logic [5:0]        io_oe_n_core,
  output logic      [5:0]        io_out,
  output logic      [5:0]        io_oe_n,
  output logic                   core_reset,
  output logic                   osc_run,
  input  wire logic              pv_mode,
  input  wire logic [PV_AW-1:0]  pv_addr,
  input  wire logic [WORD_W-1:0] pv_wdata,
  input  wire logic              pv_wr,
  input  wire logic              pv_rd,
  output logic      [WORD_W-1:0] pv_rdata,
  output logic                   pv_blocked
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pin_s1_reg, pin_s2_reg;
  logic       master_clear_n_s1_reg, master_clear_n_s2_reg, master_clear_n_d_reg;
  logic       pvm_s1_reg, pvm_s2_reg;

  // two flops before any logic looks at outside levels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      master_clear_n_s1_reg <= 1'b1;
      master_clear_n_s2_reg <= 1'b1;
      master_clear_n_d_reg  <= 1'b1;
      pvm_s1_reg  <= 1'b0;
      pvm_s2_reg  <= 1'b0;
    end else begin
      pin_s1_reg  <= port_pins;
      pin_s2_reg  <= pin_s1_reg;
      master_clear_n_s1_reg <= master_clear_n;
      master_clear_n_s2_reg <= master_clear_n_s1_reg;
      master_clear_n_d_reg  <= master_clear_n_s2_reg;
      pvm_s1_reg  <= pv_mode;
      pvm_s2_reg  <= pvm_s1_reg;
    end
  end

  // ****************************************
  // state and events
  // ****************************************
  rsw_state_e state_reg, state_next;
  logic [7:0] status_reg, pcl_reg, cfg_reg;
  logic [5:0] latch_reg;
  logic [$clog2(WDT_LIMIT+1)-1:0] wdt_reg;
  logic       ev_master_clear_n, ev_wdt, ev_pin, ev_any, sleeping, port_acc;

  assign sleeping = (state_reg == RSW_SLEEP);
  assign port_acc = (reg_wr || reg_rd) && (reg_addr == OFS_PORT);
  // falling master clear when the pin is configured for it
  assign ev_master_clear_n  = cfg_reg[CF_MASTER_CLEAR_N] && master_clear_n_d_reg && !master_clear_n_s2_reg;
  assign ev_wdt   = cfg_reg[CF_WDT]
                    && (wdt_reg == ($bits(wdt_reg))'(WDT_LIMIT - 1));
  // pins 0, 1, 3 against the last latched port values
  assign ev_pin   = sleeping && cfg_reg[CF_WAKE]
                    && (((pin_s2_reg ^ latch_reg) & WAKE_MSK) != '0);
  assign ev_any   = ev_master_clear_n || ev_wdt || ev_pin;

  // sleep state: any wake event returns to run through a reset
  always_comb begin
    case (state_reg)
      RSW_RUN:   state_next = (sleep_cmd && !ev_any) ? RSW_SLEEP : RSW_RUN;
      RSW_SLEEP: state_next = ev_any ? RSW_RUN : RSW_SLEEP;
      default:   state_next = RSW_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) state_reg <= RSW_RUN;
    else     state_reg <= state_next;
  end

  // oscillator driver off while sleeping
  assign osc_run = !sleeping;

  // reset pulse to the core; held while the clear pin stays low.
  // only an input: a watchdog reset has no path to the clear pin
  always_ff @(posedge sys_clk) begin
    if (rst) core_reset <= 1'b1;
    else     core_reset <= ev_any
               || (cfg_reg[CF_MASTER_CLEAR_N] && !master_clear_n_s2_reg);
  end

  // ****************************************
  // watchdog
  // ****************************************
  // cleared by sleep, by every wake and every reset; runs in sleep
  always_ff @(posedge sys_clk) begin
    if (rst || !cfg_reg[CF_WDT]) wdt_reg <= '0;
    else if (ev_any || (sleep_cmd && !sleeping))
      wdt_reg <= '0;
    else wdt_reg <= wdt_reg + 1'b1;
  end

  // ****************************************
  // status and program counter low
  // ****************************************
  // reset events outrank a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) status_reg <= ST_POR;
    else if (ev_master_clear_n && sleeping)
      status_reg <= {UP_MASTER_CLEAR_N_Z, status_reg[2:0]};
    else if (ev_master_clear_n)
      status_reg <= {UP_MASTER_CLEAR_N_S, status_reg[4:0]};
    else if (ev_wdt && sleeping)
      status_reg <= {UP_WDT_S, status_reg[2:0]};
    else if (ev_wdt)
      status_reg <= {4'h0, status_reg[3:0]};
    else if (ev_pin)
      status_reg <= {UP_PIN_W, status_reg[2:0]};
    else if (sleep_cmd && !sleeping) begin
      status_reg[ST_TO] <= 1'b1;
      status_reg[ST_PD] <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_STATUS)
      status_reg <= (status_reg & ~ST_WR_MSK)
                    | (reg_wdata & ST_WR_MSK);
  end

  always_ff @(posedge sys_clk) begin
    if (rst || ev_any) pcl_reg <= PCL_RST;
    else if (reg_wr && reg_addr == OFS_PCL) pcl_reg <= reg_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) cfg_reg <= CFG_RST;
    else if (reg_wr && reg_addr == OFS_CONFIG) cfg_reg <= reg_wdata;
  end

  // a file access to the port latches the pins; without one the
  // stale latch keeps a wake pending for the next sleep
  always_ff @(posedge sys_clk) begin
    if (rst) latch_reg <= '0;
    else if (port_acc) latch_reg <= pin_s2_reg;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst || !reg_rd) reg_rdata <= '0;
    else begin
      case (reg_addr)
        OFS_PCL:    reg_rdata <= pcl_reg;
        OFS_STATUS: reg_rdata <= status_reg;
        OFS_PORT:   reg_rdata <= {2'b00, pin_s2_reg};
        OFS_CONFIG: reg_rdata <= cfg_reg;
        default:    reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************
  // pin drive hold
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      io_out  <= '0;
      io_oe_n <= OE_N_RST;
    end else if (!sleeping) begin
      io_out  <= io_drive;
      io_oe_n <= io_oe_n_core;
    end
  end

  // ****************************************
  // program and verify access
  // ****************************************
  logic [WORD_W-1:0] mem [MEM_WORDS + ID_WORDS];
  logic              rd_ok;

  function automatic logic readable(input logic [PV_AW-1:0] a,
                                    input logic [7:0] cfg);
    logic ok;
    ok = !cfg[CF_CP];
    if (a < PV_AW'(OPEN_WORDS)) ok = 1'b1;
    if (a == PV_AW'(MEM_WORDS - 1)) ok = !cfg[CF_CP] || cfg[CF_LATE];
    if (a >= PV_AW'(MEM_WORDS)) ok = 1'b1; // id words
    return ok;
  endfunction

  assign rd_ok = pvm_s2_reg
                 && (pv_addr < PV_AW'(MEM_WORDS + ID_WORDS));

  always_ff @(posedge sys_clk) begin
    if (pvm_s2_reg && pv_wr
        && pv_addr < PV_AW'(MEM_WORDS + ID_WORDS))
      mem[pv_addr] <= pv_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !pv_rd) begin
      pv_rdata   <= '0;
      pv_blocked <= 1'b0;
    end else if (rd_ok && readable(pv_addr, cfg_reg)) begin
      pv_rdata   <= mem[pv_addr];
      pv_blocked <= 1'b0;
    end else begin
      pv_rdata   <= '0;
      pv_blocked <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_pcl_ones;
    @(posedge sys_clk) disable iff (rst) ev_any |=> pcl_reg == PCL_RST;
  endproperty
  a_pcl_ones: assert property (p_pcl_ones)
    else $error("pcl not all ones after reset");

  property p_master_clear_n_run;
    @(posedge sys_clk) disable iff (rst) (ev_master_clear_n && !sleeping)
      |=> status_reg[7:5] == 3'b000
          && status_reg[4:0] == $past(status_reg[4:0]);
  endproperty
  a_master_clear_n_run: assert property (p_master_clear_n_run)
    else $error("status wrong after clear while running");

  property p_master_clear_n_sleep;
    @(posedge sys_clk) disable iff (rst) (ev_master_clear_n && sleeping)
      |=> status_reg[7:3] == UP_MASTER_CLEAR_N_Z && osc_run;
  endproperty
  a_master_clear_n_sleep: assert property (p_master_clear_n_sleep)
    else $error("status wrong after clear in sleep");

  property p_wdt_sleep;
    @(posedge sys_clk) disable iff (rst) (ev_wdt && !ev_master_clear_n && sleeping)
      |=> status_reg[7:3] == UP_WDT_S && wdt_reg == '0;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep)
    else $error("status wrong after watchdog in sleep");

  property p_wdt_run;
    @(posedge sys_clk) disable iff (rst) (ev_wdt && !ev_master_clear_n && !sleeping)
      |=> !status_reg[ST_TO] && status_reg[ST_PD] == $past(status_reg[ST_PD]);
  endproperty
  a_wdt_run: assert property (p_wdt_run)
    else $error("status wrong after watchdog running");

  property p_pin_wake;
    @(posedge sys_clk) disable iff (rst) (ev_pin && !ev_master_clear_n && !ev_wdt)
      |=> status_reg[7:3] == UP_PIN_W && core_reset && osc_run;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("status wrong after pin wake");

  property p_sleep_entry;
    @(posedge sys_clk) disable iff (rst) (sleep_cmd && !sleeping && !ev_any)
      |=> status_reg[ST_TO] && !status_reg[ST_PD] && !osc_run;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry flags wrong");

  property p_io_hold;
    @(posedge sys_clk) disable iff (rst) (sleeping && $past(sleeping))
      |-> $stable(io_out) && $stable(io_oe_n);
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("pin drive changed in sleep");

  property p_open_words;
    @(posedge sys_clk) disable iff (rst)
      (pv_rd && pvm_s2_reg && pv_addr < PV_AW'(OPEN_WORDS)) |=> !pv_blocked;
  endproperty
  a_open_words: assert property (p_open_words)
    else $error("low word read blocked");

  c_sleep:  cover property (@(posedge sys_clk) sleep_cmd && !sleeping);
  c_pin:    cover property (@(posedge sys_clk) ev_pin);
  c_wdt_sl: cover property (@(posedge sys_clk) ev_wdt && sleeping);
  c_block:  cover property (@(posedge sys_clk) pv_blocked);

endmodule

// [bench/rsw_far_side.sv]
// far side model: clear pin, wake pins and programming mode pin
module rsw_far_side (
  input  wire logic       sys_clk,
  output logic            master_clear_n,
  output logic [5:0]      port_pins,
  output logic            pv_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: clear pin pulled up, programmer off
  initial begin
    master_clear_n = 1'b1;
    port_pins = 6'h00;
    pv_mode = 1'b0;
  end
  // low pulse long enough to pass the pin synchroniser
  task automatic clear_pulse();
    @(posedge sys_clk);
    master_clear_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    master_clear_n <= 1'b1;
  endtask
  // pin levels change just after an edge
  task automatic set_pins(input logic [5:0] v);
    @(posedge sys_clk);
    port_pins <= v;
  endtask
  task automatic set_pv(input logic b);
    @(posedge sys_clk);
    pv_mode <= b;
  endtask
endmodule

// [bench/rsw_core_tb.sv]
// self-checking bench for the reset, sleep and wake block
module rsw_core_tb;
  import rsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        sys_clk, rst, reg_wr, reg_rd, sleep_cmd, master_clear_n;
  logic        pv_mode, pv_wr, pv_rd, core_reset, osc_run, pv_blocked;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [5:0]  port_pins, io_drive, io_oe_n_core, io_out, io_oe_n;
  logic [9:0]  pv_addr;
  logic [11:0] pv_wdata, pv_rdata;
  int          err_count, total_checks;
  // short watchdog limit keeps the run brief
  rsw_core #(.WDT_LIMIT(20)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_cmd(sleep_cmd),
    .master_clear_n(master_clear_n), .port_pins(port_pins),
    .io_drive(io_drive), .io_oe_n_core(io_oe_n_core), .io_out(io_out),
    .io_oe_n(io_oe_n), .core_reset(core_reset), .osc_run(osc_run),
    .pv_mode(pv_mode), .pv_addr(pv_addr), .pv_wdata(pv_wdata),
    .pv_wr(pv_wr), .pv_rd(pv_rd), .pv_rdata(pv_rdata),
    .pv_blocked(pv_blocked));
  rsw_far_side u_far (.sys_clk(sys_clk), .master_clear_n(master_clear_n),
    .port_pins(port_pins), .pv_mode(pv_mode));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ****************************************
  // compare and access tasks
  // ****************************************
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t word got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, e);
  endtask
  task automatic go_sleep();
    @(posedge sys_clk);
    sleep_cmd <= 1'b1;
    @(posedge sys_clk);
    sleep_cmd <= 1'b0;
    #1 chk_bit(osc_run, 1'b0);
  endtask
  // bounded wait for a reset event, then let it settle
  task automatic wait_ev(input int lim);
    int n;
    n = 0;
    while (core_reset !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk_bit(core_reset, 1'b1);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic pv_w(input logic [9:0] a, input logic [11:0] d);
    @(posedge sys_clk);
    pv_wr <= 1'b1;
    pv_addr <= a;
    pv_wdata <= d;
    @(posedge sys_clk);
    pv_wr <= 1'b0;
  endtask
  task automatic pv_chk(input logic [9:0] a, input logic [11:0] d,
                        input logic b);
    @(posedge sys_clk);
    pv_rd <= 1'b1;
    pv_addr <= a;
    @(posedge sys_clk);
    pv_rd <= 1'b0;
    #1 chk_word(pv_rdata, d);
    chk_bit(pv_blocked, b);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, sleep_cmd, pv_wr, pv_rd} = '0;
    {reg_addr, reg_wdata, pv_addr, pv_wdata} = '0;
    {io_drive, io_oe_n_core} = 12'h003f;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    wr(OFS_CONFIG, 8'h04);
    rd(OFS_STATUS, 8'h18);
    chk_word({io_oe_n, io_out}, 12'hfc0);
    rd(OFS_PCL, 8'hff);
    wr(OFS_STATUS, 8'hff);
    rd(OFS_STATUS, 8'h7f);
    wr(OFS_PCL, 8'h12);
    u_far.clear_pulse();
    wait_ev(40);
    rd(OFS_STATUS, 8'h1f);
    rd(OFS_PCL, 8'hff);
    // pins frozen and oscillator stopped while asleep
    io_oe_n_core <= 6'h00;
    io_drive <= 6'h2a;
    wr(OFS_STATUS, 8'h45);
    go_sleep();
    rd(OFS_STATUS, 8'h55);
    io_drive <= 6'h15;
    io_oe_n_core <= 6'h3f;
    repeat (3) @(posedge sys_clk);
    #1 chk_word({io_oe_n, io_out}, 12'h02a);
    u_far.clear_pulse();
    wait_ev(40);
    rd(OFS_STATUS, 8'h15);
    chk_bit(osc_run, 1'b1);
    chk_word({io_oe_n, io_out}, 12'hfd5);
    // watchdog while running, then while asleep
    wr(OFS_CONFIG, 8'h05);
    wr(OFS_STATUS, 8'h65);
    wait_ev(40);
    rd(OFS_STATUS, 8'h05);
    go_sleep();
    wait_ev(40);
    rd(OFS_STATUS, 8'h05);
    // pin change wake and stale latch
    wr(OFS_CONFIG, 8'h06);
    u_far.set_pins(6'h00);
    repeat (3) @(posedge sys_clk);
    rd(OFS_PORT, 8'h00);
    go_sleep();
    u_far.set_pins(6'h01);
    wait_ev(20);
    rd(OFS_STATUS, 8'h95);
    rd(OFS_PCL, 8'hff);
    go_sleep();
    wait_ev(12);
    rd(OFS_PORT, 8'h01);
    go_sleep();
    u_far.set_pins(6'h05);
    repeat (12) @(posedge sys_clk);
    #1 chk_bit(osc_run, 1'b0);
    u_far.clear_pulse();
    wait_ev(40);
    rd(OFS_STATUS, 8'h15);
    // program and verify readout
    u_far.set_pv(1'b1);
    repeat (3) @(posedge sys_clk);
    pv_w(10'd63, 12'h3f3);
    pv_w(10'd64, 12'h456);
    pv_w(10'd511, 12'h123);
    pv_w(10'd512, 12'h00a);
    pv_chk(10'd64, 12'h456, 1'b0);
    wr(OFS_CONFIG, 8'h0c);
    pv_chk(10'd63, 12'h3f3, 1'b0);
    pv_chk(10'd64, 12'h000, 1'b1);
    pv_chk(10'd511, 12'h000, 1'b1);
    pv_chk(10'd512, 12'h00a, 1'b0);
    wr(OFS_CONFIG, 8'h1c);
    pv_chk(10'd511, 12'h123, 1'b0);
    u_far.set_pv(1'b0);
    repeat (3) @(posedge sys_clk);
    pv_chk(10'd512, 12'h000, 1'b1);
    complete_run();
  end
endmodule
